// *** gpbl_pkg.sv ***
// package: register map, field layout and reset values of the bitmask line block
package gpbl_pkg;

    // ------------------------------------------------------------------
    // line geometry
    // ------------------------------------------------------------------
    localparam int NUM_LINES = 23;                     // lines 0..22
    localparam int FIRST_PORT_BASE = 0;                // lines 0-7
    localparam int SECOND_PORT_BASE = 8;               // lines 8-15
    localparam int THIRD_PORT_BASE = 16;               // lines 16-19
    localparam int MUX_PORT_BASE = 20;                 // lines 20-22
    localparam int MUX_PORT_WIDTH = 3;
    localparam int REDUCED_ABSENT_LINES = 4;           // lines 0-3 missing on reduced variant

    // ------------------------------------------------------------------
    // register addresses (16-bit register numbers)
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_FIRST_PORT_LINE_REGS = 16'h07D0;   // 2000, lines 0-7
    localparam logic [15:0] ADDR_SECOND_PORT_LINE_REGS = 16'h07D8;  // 2008, lines 8-15
    localparam logic [15:0] ADDR_THIRD_PORT_LINE_REGS = 16'h07E0;   // 2016, lines 16-19
    localparam logic [15:0] ADDR_MUX_PORT_LINE_REGS = 16'h07E4;     // 2020, lines 20-22
    localparam logic [15:0] ADDR_ALL_LINES_LEVEL_WORD = 16'h0AF0;   // 2800
    localparam logic [15:0] ADDR_ALL_LINES_DIRECTION_WORD = 16'h0B22; // 2850
    localparam logic [15:0] ADDR_ALL_LINES_WRITE_MASK = 16'h0B54;   // 2900

    // ------------------------------------------------------------------
    // reset values and field masks
    // ------------------------------------------------------------------
    localparam logic [22:0] RESET_DIRECTION = 23'h000000;  // all inputs
    localparam logic [22:0] RESET_LEVEL = 23'h000000;
    localparam logic [22:0] RESET_WRITE_MASK = 23'h000000; // all lines affected
    localparam logic [22:0] ALL_LINES = 23'h7FFFFF;
    localparam logic [22:0] REDUCED_LINES = 23'h7FFFF0;    // lines 0-3 absent

    // ------------------------------------------------------------------
    // analog channel range that hands the mux port to the analog side
    // ------------------------------------------------------------------
    localparam logic [7:0] MUX_CHANNEL_FIRST = 8'h10;      // 16
    localparam logic [7:0] MUX_CHANNEL_LAST = 8'h7F;       // 127
    localparam int MUX_SELECT_SHIFT = 4;                   // channel bits 6:4 drive the mux

endpackage : gpbl_pkg

// *** gpbl_sync.sv ***
// two flip-flop synchroniser for the pin inputs, one stage pair per line
`timescale 1ns/1ps

module gpbl_sync #(
    parameter int WIDTH = 23
) (
    input wire logic clk,                  // system clock
    input wire logic srst,                 // synchronous reset, active high
    input wire logic [WIDTH-1:0] async_in, // raw pin levels
    output logic [WIDTH-1:0] sync_out      // levels after two stages
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } gpbl_sync_state_t;

    gpbl_sync_state_t state;
    gpbl_sync_state_t next_state;

    // ------------------------------------------------------------------
    // per-line stage pair; stage1 is read by stage2 only
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        for (int i = 0; i < WIDTH; i++) begin
            next_state.stage1[i] = async_in[i];
            next_state.stage2[i] = state.stage1[i];
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;

endmodule : gpbl_sync

// *** gpbl_line_ctrl.sv ***
// top module: bitmask and per-line register control of the general-purpose lines
//
// Notes on behaviour
// - each set write-mask bit shields its line from direction, level, analog-select writes
// - direction word: 0 input, 1 output; writes only unmasked lines, reads all
// - level word write sets output values of unmasked lines, direction untouched
// - level word read returns sampled pin levels, also for output lines
// - a set mask bit blocks direction and level word changes; per-line register accesses ignore it
// - bit n of every bitmask word is line n; lines 0 to 22 valid
// - on the reduced variant bits 0-3 of the bitmask words have no effect
// - per-line register read makes line input; write makes it output at that level
// - ports 0-7, 8-15, 16-19, 20-22 with aliases from 2000, 2008, 2016, 2020
// - analog channel 16 to 127 selected drives mux port lines automatically on the full variant
`timescale 1ns/1ps

module gpbl_line_ctrl #(
    parameter bit REDUCED_VARIANT = 1'b0     // 1: lines 0-3 are not digital lines
) (
    input wire logic clk,                    // 250 MHz system clock
    input wire logic srst,                   // synchronous reset, active high
    input wire logic reg_req,                // register access request, one cycle
    input wire logic reg_write,              // 1 write, 0 read
    input wire logic [15:0] reg_addr,        // register number
    input wire logic [31:0] reg_wdata,       // write data
    output logic [31:0] reg_rdata,           // read data, valid with reg_ack
    output logic reg_ack,                    // access done, one-cycle pulse
    input wire logic ain_select_valid,       // analog channel selection is active
    input wire logic [7:0] ain_channel,      // selected analog channel number
    input wire logic analog_sel_write,       // write strobe for analog-select bits
    input wire logic [22:0] analog_sel_wdata,// requested analog-select bits per line
    output logic [22:0] analog_sel,          // analog-select setting per line
    input wire logic [22:0] line_in,         // pin levels, asynchronous
    output logic [22:0] line_out,            // pin output values
    output logic [22:0] line_oe              // pin output enables, high drives
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [22:0] direction;
        logic [22:0] level;
        logic [22:0] write_mask;
        logic [22:0] analog;
        logic [22:0] pin_out;
        logic [22:0] pin_oe;
        logic [31:0] rdata;
        logic ack;
    } gpbl_state_t;

    gpbl_state_t state;
    gpbl_state_t next_state;

    logic [22:0] pin_level;        // synchronised pin levels
    logic [22:0] valid_lines;      // lines that exist as digital lines
    logic [15:0] line_offset;      // register number minus first per-line address
    logic per_line_hit;            // access falls on a per-line register
    logic [4:0] line_idx;          // line addressed by a per-line register
    logic mux_override;            // analog side owns the mux port
    logic [2:0] mux_select;        // select code for the external mux
    logic [22:0] mux_oe;           // per line: the analog side drives this line
    logic [22:0] mux_out;          // per line: value the analog side drives

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    gpbl_sync #(
        .WIDTH(gpbl_pkg::NUM_LINES)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .async_in(line_in),
        .sync_out(pin_level)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    // reduced variant drops lines 0-3; bits above 22 do not exist at all
    assign valid_lines = REDUCED_VARIANT ? gpbl_pkg::REDUCED_LINES
                                         : gpbl_pkg::ALL_LINES;

    // the four port aliases are contiguous, so one offset names the line
    assign line_offset = reg_addr - gpbl_pkg::ADDR_FIRST_PORT_LINE_REGS;
    assign line_idx = line_offset[4:0];
    // absent lines on the reduced variant fall through to the unmapped path
    assign per_line_hit = (reg_addr >= gpbl_pkg::ADDR_FIRST_PORT_LINE_REGS)
                        && (line_offset < 16'(gpbl_pkg::NUM_LINES))
                        && valid_lines[line_idx];

    // analog channels 16..127 hand the mux port to the analog front end on the full variant
    assign mux_override = ain_select_valid
                        && (ain_channel >= gpbl_pkg::MUX_CHANNEL_FIRST)
                        && (ain_channel <= gpbl_pkg::MUX_CHANNEL_LAST)
                        && !REDUCED_VARIANT;
    assign mux_select = 3'(ain_channel >> gpbl_pkg::MUX_SELECT_SHIFT);

    // ------------------------------------------------------------------
    // mux hand-over per line; only the three mux port lines can be taken
    // ------------------------------------------------------------------
    for (genvar g = 0; g < gpbl_pkg::NUM_LINES; g++) begin : g_mux_line
        if (g >= gpbl_pkg::MUX_PORT_BASE
                && g < gpbl_pkg::MUX_PORT_BASE + gpbl_pkg::MUX_PORT_WIDTH) begin : g_taken
            // analog side wins over the registers while it scans channels
            assign mux_oe[g] = mux_override;
            assign mux_out[g] = mux_select[g - gpbl_pkg::MUX_PORT_BASE];
        end else begin : g_free
            // digital-only lines are never handed over
            assign mux_oe[g] = 1'b0;
            assign mux_out[g] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [22:0] wbits;
        logic [22:0] keep;
        logic [22:0] drive_out;
        logic [22:0] drive_oe;
        wbits = reg_wdata[22:0] & valid_lines;
        keep = state.write_mask | ~valid_lines;
        drive_out = '0;
        drive_oe = '0;
        next_state = state;
        next_state.ack = 1'b0;
        next_state.rdata = '0;

        // register accesses answer one cycle after the request
        if (reg_req) begin
            next_state.ack = 1'b1;
            if (per_line_hit) begin
                if (reg_write) begin
                    // per-line write turns the line into a driven output
                    next_state.direction[line_idx] = 1'b1;
                    next_state.level[line_idx] = reg_wdata[0];
                end else begin
                    // per-line read returns the pin as sampled before the line turns into an input
                    next_state.direction[line_idx] = 1'b0;
                    next_state.rdata = {31'h00000000, pin_level[line_idx]};
                end
            end else begin
                case (reg_addr)
                    gpbl_pkg::ADDR_ALL_LINES_LEVEL_WORD: begin
                        if (reg_write) begin
                            // level bits only; direction stays as it is
                            next_state.level = (state.level & keep) | (wbits & ~keep);
                        end else begin
                            // the pin itself, never the latched output value
                            next_state.rdata = {9'h000, pin_level & valid_lines};
                        end
                    end
                    gpbl_pkg::ADDR_ALL_LINES_DIRECTION_WORD: begin
                        if (reg_write) begin
                            next_state.direction = (state.direction & keep)
                                                 | (wbits & ~keep);
                        end else begin
                            next_state.rdata = {9'h000, state.direction & valid_lines};
                        end
                    end
                    gpbl_pkg::ADDR_ALL_LINES_WRITE_MASK: begin
                        if (reg_write) begin
                            next_state.write_mask = wbits;
                        end else begin
                            next_state.rdata = {9'h000, state.write_mask};
                        end
                    end
                    default: begin
                        // unmapped number: acknowledged, writes dropped, reads zero
                        next_state.rdata = '0;
                    end
                endcase
            end
        end

        // analog-select setting obeys the same write mask
        // uses the mask held before this cycle, like the register writes
        if (analog_sel_write) begin
            next_state.analog = (state.analog & keep) | (analog_sel_wdata & valid_lines & ~keep);
        end

        // pin drive: register view, then the mux override on lines 20-22
        // built from next_state so a write shows on the pins with its ack
        drive_out = (next_state.level & valid_lines & ~mux_oe) | (mux_out & mux_oe);
        drive_oe = (next_state.direction & valid_lines & ~next_state.analog) | mux_oe;
        next_state.pin_out = drive_out;
        next_state.pin_oe = drive_oe;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        // reset releases every pin, so nothing is driven before the host configures it
        if (srst) begin
            state.direction <= gpbl_pkg::RESET_DIRECTION;
            state.level <= gpbl_pkg::RESET_LEVEL;
            state.write_mask <= gpbl_pkg::RESET_WRITE_MASK;
            state.analog <= '0;
            state.pin_out <= '0;
            state.pin_oe <= '0;
            state.rdata <= '0;
            state.ack <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign reg_rdata = state.rdata;
    assign reg_ack = state.ack;
    assign analog_sel = state.analog;
    assign line_out = state.pin_out;
    assign line_oe = state.pin_oe;

endmodule : gpbl_line_ctrl

// *** gpbl_line_sva.sv ***
// checker: port-level timing and masking properties of the bitmask line block
`timescale 1ns/1ps
module gpbl_line_sva #(
    parameter bit REDUCED_VARIANT = 1'b0 // 1: lines 0-3 absent
) (
    input wire logic clk, // clock
    input wire logic srst, // sync reset
    input wire logic reg_req, // request
    input wire logic reg_write, // write
    input wire logic [15:0] reg_addr, // address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic [31:0] reg_rdata, // read data
    input wire logic reg_ack, // ack
    input wire logic ain_select_valid, // channel active
    input wire logic [7:0] ain_channel, // channel
    input wire logic analog_sel_write, // analog strobe
    input wire logic [22:0] analog_sel_wdata, // analog data
    input wire logic [22:0] analog_sel, // analog setting
    input wire logic [22:0] line_in, // pins
    input wire logic [22:0] line_out, // outputs
    input wire logic [22:0] line_oe // enables
);
    // ----------------------------------------
    // shadow mask and decode
    // ----------------------------------------
    logic [22:0] mask_q;
    // lines that exist as digital lines on this variant
    localparam logic [22:0] VALID = REDUCED_VARIANT ? gpbl_pkg::REDUCED_LINES
                                                    : gpbl_pkg::ALL_LINES;
    // mux and analog both override oe, so only judge when neither is active
    wire quiet = !ain_select_valid && analog_sel == 23'h0;
    wire is_line = (reg_addr - gpbl_pkg::ADDR_FIRST_PORT_LINE_REGS) < 16'h0017
        && VALID[5'(reg_addr - gpbl_pkg::ADDR_FIRST_PORT_LINE_REGS)];
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_q <= 23'h0;
        end else if (reg_req && reg_write && reg_addr == gpbl_pkg::ADDR_ALL_LINES_WRITE_MASK) begin
            mask_q <= reg_wdata[22:0] & VALID;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_wr(logic [15:0] a); reg_req && reg_write && reg_addr == a; endsequence
    sequence s_rd(logic [15:0] a); reg_req && !reg_write && reg_addr == a; endsequence
    sequence s_pins_still; $stable(line_in) [*4]; endsequence
    a_ack_next: assert property (reg_req |=> reg_ack)
        else $error("no ack after request");
    a_ack_cause: assert property (reg_ack |-> $past(reg_req))
        else $error("ack without request");
    a_rdata_upper: assert property (reg_ack |-> reg_rdata[31:23] == 9'h0)
        else $error("upper read bits set");
    a_dir_mask: assert property (s_wr(gpbl_pkg::ADDR_ALL_LINES_DIRECTION_WORD) ##0 quiet
        |=> line_oe == (($past(line_oe) & mask_q)
        | ($past(reg_wdata[22:0]) & ~mask_q & VALID)))
        else $error("direction write ignored mask");
    a_level_mask: assert property (s_wr(gpbl_pkg::ADDR_ALL_LINES_LEVEL_WORD) ##0 quiet
        |=> $stable(line_oe) && line_out ==
        (($past(line_out) & mask_q) | ($past(reg_wdata[22:0]) & ~mask_q & VALID)))
        else $error("level write wrong");
    a_level_pins: assert property (s_pins_still ##0 s_rd(gpbl_pkg::ADDR_ALL_LINES_LEVEL_WORD)
        |=> reg_rdata == {9'h0, $past(line_in) & VALID}) else $error("level read not pins");
    a_line_write: assert property (reg_req && reg_write && is_line && quiet
        |=> line_oe[$past(reg_addr) - 16'h07D0] && line_out[$past(reg_addr) - 16'h07D0]
        == $past(reg_wdata[0])) else $error("line write wrong");
    a_line_read: assert property (reg_req && !reg_write && is_line && quiet
        |=> !line_oe[$past(reg_addr) - 16'h07D0]) else $error("line read kept output");
    a_mux_drive: assert property (!REDUCED_VARIANT && ain_select_valid
        && ain_channel inside {[8'h10:8'h7F]}
        && analog_sel == 23'h0 |=> line_oe[22:20] == 3'h7
        && line_out[22:20] == $past(ain_channel[6:4])) else $error("mux lines wrong");
    a_analog_mask: assert property (analog_sel_write |=>
        ((analog_sel ^ $past(analog_sel)) & mask_q) == 23'h0) else $error("analog ignored mask");
    a_absent_idle: assert property ((line_oe & ~VALID) == 23'h0)
        else $error("absent line driven");
endmodule : gpbl_line_sva

// *** gpbl_pin_model.sv ***
// pin model: resolves each line between the block's drive and the outside circuit
`timescale 1ns/1ps
module gpbl_pin_model (
    input wire logic [22:0] line_out, // driven values
    input wire logic [22:0] line_oe, // drive enables
    input wire logic [22:0] ext_level, // outside circuit level
    output logic [22:0] line_in // resolved pins
);
    // a driven pin follows the block, a released one the outside circuit
    assign line_in = (line_out & line_oe) | (ext_level & ~line_oe);
endmodule : gpbl_pin_model

// *** testbench.sv ***
// testbench: host register traffic and pin stimulus for the bitmask line block
`timescale 1ns/1ps
module testbench;
    logic clk = 1'h0, srst = 1'h1, reg_req = 1'h0, reg_write = 1'h0, reg_ack, mux, ack_r;
    logic ain_select_valid = 1'h0, analog_sel_write = 1'h0;
    logic [15:0] reg_addr = 16'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd, rdata_r, rd_r;
    logic [7:0] ain_channel = 8'h0, ch;
    logic [7:0] ch_tab [4] = '{8'h0F, 8'h10, 8'h7F, 8'h80};
    logic [22:0] analog_sel_wdata = 23'h0, analog_sel, line_in, line_out, line_oe, ext = 23'h0;
    logic [22:0] dir_e = 23'h0, lvl_e = 23'h0, an_e = 23'h0, m, d, v;
    logic [22:0] an_r, out_r, oe_r;
    int num_errors = 0, n_tests = 0, b;
    localparam logic [15:0] MK = gpbl_pkg::ADDR_ALL_LINES_WRITE_MASK;
    localparam logic [15:0] DR = gpbl_pkg::ADDR_ALL_LINES_DIRECTION_WORD;
    localparam logic [15:0] LV = gpbl_pkg::ADDR_ALL_LINES_LEVEL_WORD;
    localparam logic [15:0] PL = gpbl_pkg::ADDR_FIRST_PORT_LINE_REGS;
    localparam logic [22:0] RL = gpbl_pkg::REDUCED_LINES;
    gpbl_line_ctrl dut (.clk(clk), .srst(srst), .reg_req(reg_req), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .ain_select_valid(ain_select_valid), .ain_channel(ain_channel),
        .analog_sel_write(analog_sel_write), .analog_sel_wdata(analog_sel_wdata),
        .analog_sel(analog_sel), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));
    gpbl_pin_model pins (.line_out(line_out), .line_oe(line_oe), .ext_level(ext), .line_in(line_in));
    // reduced variant on the same bus and pins: lines 0-3 must stay dead
    gpbl_line_ctrl #(.REDUCED_VARIANT(1'b1)) dut_r (.clk(clk), .srst(srst), .reg_req(reg_req),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata_r),
        .reg_ack(ack_r), .ain_select_valid(ain_select_valid), .ain_channel(ain_channel),
        .analog_sel_write(analog_sel_write), .analog_sel_wdata(analog_sel_wdata),
        .analog_sel(an_r), .line_in(line_in), .line_out(out_r), .line_oe(oe_r));
    // ----------------------------------------
    // clock, watchdog, helpers
    // ----------------------------------------
    initial begin
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    function automatic logic [22:0] mrg(input logic [22:0] o, n, k);
        return (o & k) | (n & ~k);
    endfunction : mrg
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one access; request held for exactly the taking edge, ack read 1 ns after that edge
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] wd);
        @(posedge clk);
        reg_req <= 1'h1;
        reg_write <= w;
        reg_addr <= a;
        reg_wdata <= wd;
        @(posedge clk);
        reg_req <= 1'h0;
        #1;
        chk("ack", 32'(reg_ack), 32'h1);
        chk("ack_r", 32'(ack_r), 32'h1);
        rd = reg_rdata;
        rd_r = rdata_r;
    endtask : acc
    // new outside levels, then let the two-stage synchroniser settle
    task automatic wt;
        @(posedge clk);
        ext <= 23'($urandom);
        repeat (3) @(posedge clk);
    endtask : wt
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        b = $urandom(32'h4AAB32A6);
        repeat (12) @(posedge clk);
        srst <= 1'h0;
        acc(1'h0, MK, 32'h0);
        chk("mask_rst", rd, 32'h0);
        // documented walk first, then random bank writes with junk upper bits
        for (int i = 0; i < 24; i++) begin
            m = (i == 0) ? 23'h7FFFCF : 23'($urandom);
            d = (i == 0) ? 23'h000030 : 23'($urandom);
            v = (i == 0) ? 23'h000030 : 23'($urandom);
            acc(1'h1, MK, {9'h1FF, m});
            acc(1'h1, DR, {9'h1FF, d});
            acc(1'h1, LV, {9'h1FF, v});
            dir_e = mrg(dir_e, d, m);
            lvl_e = mrg(lvl_e, v, m);
            chk("oe", 32'(line_oe), 32'(dir_e));
            chk("out", 32'(line_out & dir_e), 32'(lvl_e & dir_e));
            chk("oe_rdc", 32'(oe_r), 32'(dir_e & RL));
            chk("out_rdc", 32'(out_r), 32'(lvl_e & RL));
            wt();
            acc(1'h0, MK, 32'h0);
            chk("mask_rd", rd, 32'(m));
            chk("mask_rd_r", rd_r, 32'(m & RL));
            acc(1'h0, DR, 32'h0);
            chk("dir_rd", rd, 32'(dir_e));
            chk("dir_rd_r", rd_r, 32'(dir_e & RL));
            acc(1'h0, LV, 32'h0);
            chk("lvl_rd", rd, 32'((dir_e & lvl_e) | (~dir_e & ext)));
            chk("lvl_rd_r", rd_r, 32'(((dir_e & lvl_e) | (~dir_e & ext)) & RL));
        end
        // every per-line alias ignores the mask and flips direction
        for (int i = 0; i < 23; i++) begin
            b = $urandom % 2;
            acc(1'h1, PL + 16'(i), 32'(b));
            chk("line_oe", 32'(line_oe[i]), 32'h1);
            chk("line_oe_r", 32'(oe_r[i]), 32'(i >= 4));
            chk("line_out", 32'(line_out[i]), 32'(b));
            wt();
            acc(1'h0, PL + 16'(i), 32'h0);
            chk("line_rd", rd, 32'(b));
            chk("line_rd_r", rd_r, (i >= 4) ? 32'(b) : 32'h0);
            chk("line_in_dir", 32'(line_oe[i]), 32'h0);
            dir_e[i] = 1'h0;
        end
        acc(1'h1, 16'h0BFF, 32'hFFFFFFFF);
        chk("unmapped_oe", 32'(line_oe), 32'(dir_e));
        acc(1'h0, 16'h0BFF, 32'h0);
        chk("unmapped_rd", rd, 32'h0);
        // channel range edges, then random channels
        for (int i = 0; i < 8; i++) begin
            ch = (i < 4) ? ch_tab[i] : 8'($urandom);
            mux = ch inside {[8'h10:8'h7F]};
            @(posedge clk);
            ain_select_valid <= 1'h1;
            ain_channel <= ch;
            repeat (2) @(posedge clk);
            #1;
            chk("mux_oe", 32'(line_oe[22:20]), mux ? 32'h7 : 32'(dir_e[22:20]));
            chk("mux_out", 32'(line_out[22:20] & {3{mux}}), 32'(ch[6:4] & {3{mux}}));
            chk("mux_oe_r", 32'(oe_r[22:20]), 32'h0);
        end
        @(posedge clk);
        ain_select_valid <= 1'h0;
        for (int i = 0; i < 6; i++) begin
            m = 23'($urandom);
            d = 23'($urandom);
            acc(1'h1, MK, 32'(m));
            @(posedge clk);
            analog_sel_write <= 1'h1;
            analog_sel_wdata <= d;
            @(posedge clk);
            analog_sel_write <= 1'h0;
            an_e = mrg(an_e, d, m);
            @(posedge clk);
            chk("analog", 32'(analog_sel), 32'(an_e));
            chk("analog_r", 32'(an_r), 32'(an_e & RL));
        end
        end_sim();
    end
endmodule : testbench
bind gpbl_line_ctrl gpbl_line_sva #(.REDUCED_VARIANT(REDUCED_VARIANT)) u_sva (.clk(clk),
    .srst(srst), .reg_req(reg_req),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .ain_select_valid(ain_select_valid), .ain_channel(ain_channel),
    .analog_sel_write(analog_sel_write), .analog_sel_wdata(analog_sel_wdata),
    .analog_sel(analog_sel), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));
